// >>> verilog/occ_config_bank.sv
// configuration bank and output control for channels 0 to 3
module occ_config_bank
    import occ_pkg::*;
(
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    // decoded side of the serial configuration port
    input  wire logic [occ_pkg::ADDR_W-1:0]  cfg_addr,
    input  wire logic [occ_pkg::DATA_W-1:0]  cfg_wdata,
    input  wire logic                        cfg_write,
    input  wire logic                        cfg_read,
    output logic      [occ_pkg::DATA_W-1:0]  cfg_rdata,
    output logic                             cfg_rvalid,
    // channel outputs, index = channel number
    output logic      [3:0]                  chan_level,
    output logic      [3:0]                  chan_drive,
    output logic      [3:0]                  chan_lvds,
    output logic      [3:0]                  chan_cml,
    output logic      [3:0]                  chan_pecl,
    // pair supply selections
    output logic                             pair_a_supply_select,
    output logic                             pair_b_supply_select
);
    import occ_pkg::*;

    logic [CTRL_USED_W-1:0] ch01_ctrl_reg;
    logic [CTRL_USED_W-1:0] ch23_ctrl_reg;
    logic [DIV_W-1:0]       pair_a_integer_divider;
    logic [DIV_W-1:0]       pair_b_integer_divider;
    logic [1:0]             pair_div;
    logic [1:0]             en_code   [4];
    logic [1:0]             type_code [4];

    function automatic occ_drv_type drv_decode(input logic [1:0] code);
        unique case (code)
            2'h2:    drv_decode = OCC_DRV_CML;
            2'h3:    drv_decode = OCC_DRV_PECL;
            default: drv_decode = OCC_DRV_LVDS;
        endcase
    endfunction

    // reserved bits are dropped on write; the host must send them as zero
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ch01_ctrl_reg <= CTRL_RESET;
            ch23_ctrl_reg <= CTRL_RESET;
        end else if (cfg_write) begin
            if (cfg_addr == CH01_CTRL_OFS) begin
                ch01_ctrl_reg <= cfg_wdata[CTRL_USED_W-1:0]; // see RULE1
            end
            if (cfg_addr == CH23_CTRL_OFS) begin
                ch23_ctrl_reg <= cfg_wdata[CTRL_USED_W-1:0]; // see RULE11
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pair_a_integer_divider <= DIV_RESET;
            pair_b_integer_divider <= DIV_RESET;
        end else if (cfg_write) begin
            if (cfg_addr == CH01_DIV_OFS) begin
                pair_a_integer_divider <= cfg_wdata[DIV_W-1:0]; // see RULE2
            end
            if (cfg_addr == CH23_DIV_OFS) begin
                pair_b_integer_divider <= cfg_wdata[DIV_W-1:0]; // see RULE3
            end
        end
    end

    // read data one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cfg_rdata  <= '0;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_read;
            if (cfg_read) begin
                unique case (cfg_addr)
                    CH01_CTRL_OFS: cfg_rdata <= {7'h00, ch01_ctrl_reg};
                    CH01_DIV_OFS:  cfg_rdata <= {8'h00, pair_a_integer_divider};
                    CH23_CTRL_OFS: cfg_rdata <= {7'h00, ch23_ctrl_reg};
                    CH23_DIV_OFS:  cfg_rdata <= {8'h00, pair_b_integer_divider};
                    default:       cfg_rdata <= 16'h0000; // see RULE11
                endcase
            end
        end
    end

    occ_pair_divider u_pair_a (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .ratio_code (pair_a_integer_divider),
        .div_level  (pair_div[0])
    );

    occ_pair_divider u_pair_b (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .ratio_code (pair_b_integer_divider),
        .div_level  (pair_div[1])
    );

    // field slices per channel; channel 2 is the low half of its register
    assign en_code[0]   = ch01_ctrl_reg[EN_LO_POS+:2];
    assign en_code[1]   = ch01_ctrl_reg[EN_HI_POS+:2];
    assign en_code[2]   = ch23_ctrl_reg[EN_LO_POS+:2];   // see RULE5
    assign en_code[3]   = ch23_ctrl_reg[EN_HI_POS+:2];   // see RULE4
    assign type_code[0] = ch01_ctrl_reg[TYPE_LO_POS+:2];
    assign type_code[1] = ch01_ctrl_reg[TYPE_HI_POS+:2];
    assign type_code[2] = ch23_ctrl_reg[TYPE_LO_POS+:2]; // see RULE7
    assign type_code[3] = ch23_ctrl_reg[TYPE_HI_POS+:2]; // see RULE6

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_chan
            // enable code picks off, divided clock or a static level
            always_ff @(posedge mclk) begin
                if (!rst_b) begin
                    chan_level[ch] <= 1'b0;
                    chan_drive[ch] <= 1'b0;
                end else begin
                    unique case (en_code[ch])
                        EN_OFF: begin
                            chan_level[ch] <= 1'b0;
                            chan_drive[ch] <= 1'b0;
                        end
                        EN_CLOCK: begin
                            chan_level[ch] <= pair_div[ch/2]; // see RULE4
                            chan_drive[ch] <= 1'b1;
                        end
                        EN_LOW: begin
                            chan_level[ch] <= 1'b0;           // see RULE5
                            chan_drive[ch] <= 1'b1;
                        end
                        EN_HIGH: begin
                            chan_level[ch] <= 1'b1;
                            chan_drive[ch] <= 1'b1;
                        end
                    endcase
                end
            end

            always_ff @(posedge mclk) begin
                if (!rst_b) begin
                    chan_lvds[ch] <= 1'b1;
                    chan_cml[ch]  <= 1'b0;
                    chan_pecl[ch] <= 1'b0;
                end else begin
                    chan_lvds[ch] <= drv_decode(type_code[ch])
                                     == OCC_DRV_LVDS; // see RULE6
                    chan_cml[ch]  <= drv_decode(type_code[ch])
                                     == OCC_DRV_CML;  // see RULE7
                    chan_pecl[ch] <= drv_decode(type_code[ch])
                                     == OCC_DRV_PECL;
                end
            end
        end
    endgenerate

    // zero after reset is safe on any supply; software corrects it later
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pair_a_supply_select <= 1'b0;
            pair_b_supply_select <= 1'b0;
        end else begin
            pair_a_supply_select <= ch01_ctrl_reg[SUPPLY_BIT]; // see RULE9
            pair_b_supply_select <= ch23_ctrl_reg[SUPPLY_BIT]; // see RULE8
        end
    end

endmodule // occ_config_bank

// >>> shared/occ_pkg.sv
// constants and types for the output channel 0-3 configuration bank
// What this block does
// RULE1: the host writes zero to every reserved bit of the divider and control registers.
// RULE2: channels 0 and 1 share one integer divider whose ratio is the 8-bit field plus one.
// RULE3: channels 2 and 3 share one integer divider whose ratio is the 8-bit field plus one.
// RULE4: channel 3 follows its enable code: 00 off, 01 clock, 10 static low, 11 static high.
// RULE5: channel 2 follows its enable code with the same four meanings.
// RULE6: channel 3 driver type is LVDS for 00 or 01, CML for 10 and PECL for 11.
// RULE7: channel 2 driver type is LVDS for 00 or 01, CML for 10 and PECL for 11.
// RULE8: the channel 2/3 supply bit means 1.8 V when clear and 2.5 or 3.3 V when set.
// RULE9: the channel 0/1 supply bit sits at bit 0, 1.8 V when clear, 2.5 or 3.3 V when set.
// RULE10: the host may power up on 2.5 or 3.3 V with a supply bit at zero and fix it later.
// RULE11: each field keeps its last written value and reads back as stored.
package occ_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int DIV_W  = 8;

    // register offsets
    localparam logic [3:0] CH01_CTRL_OFS = 4'h5;
    localparam logic [3:0] CH01_DIV_OFS  = 4'h6;
    localparam logic [3:0] CH23_CTRL_OFS = 4'h7;
    localparam logic [3:0] CH23_DIV_OFS  = 4'h8;

    // control register field positions (shared by both control registers)
    localparam int SUPPLY_BIT  = 0;
    localparam int EN_LO_POS   = 1;
    localparam int TYPE_LO_POS = 3;
    localparam int EN_HI_POS   = 5;
    localparam int TYPE_HI_POS = 7;
    localparam int CTRL_USED_W = 9;

    // values after reset
    localparam logic [8:0] CTRL_RESET = 9'h000;
    localparam logic [7:0] DIV_RESET  = 8'h00;

    // enable codes
    localparam logic [1:0] EN_OFF    = 2'h0;
    localparam logic [1:0] EN_CLOCK  = 2'h1;
    localparam logic [1:0] EN_LOW    = 2'h2;
    localparam logic [1:0] EN_HIGH   = 2'h3;

    // driver type, one-hot
    typedef enum logic [2:0] {
        OCC_DRV_LVDS = 3'b001,
        OCC_DRV_CML  = 3'b010,
        OCC_DRV_PECL = 3'b100
    } occ_drv_type;

endpackage

// >>> verilog/occ_pair_divider.sv
// integer divider shared by one channel pair
module occ_pair_divider
    import occ_pkg::*;
(
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst_b,
    // ratio code, ratio = code + 1
    input  wire logic [occ_pkg::DIV_W-1:0] ratio_code,
    // divided level
    output logic                        div_level
);
    import occ_pkg::*;

    logic [DIV_W-1:0] count_reg;
    logic [DIV_W:0]   half;

    // high phase takes the larger half for odd ratios
    assign half = ({1'b0, ratio_code} + 9'h002) >> 1;

    // a code lowered mid-period wraps at once instead of running to 255
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            count_reg <= '0;
        end else if (count_reg >= ratio_code) begin // see RULE2
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + 8'h01;
        end
    end

    // ratio 1 cannot toggle on a flop, so it shows as a steady high
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            div_level <= 1'b0;
        end else begin
            div_level <= ({1'b0, count_reg} < half); // see RULE3
        end
    end

endmodule // occ_pair_divider

// >>> tb/occ_bank_properties.sv
// assertion checker for the channel 0-3 configuration bank
module occ_bank_props
    import occ_pkg::*;
(
    // clock, reset and register port
    input wire logic                       mclk,
    input wire logic                       rst_b,
    input wire logic [occ_pkg::ADDR_W-1:0] cfg_addr,
    input wire logic [occ_pkg::DATA_W-1:0] cfg_wdata,
    input wire logic                       cfg_write,
    input wire logic                       cfg_read,
    input wire logic [occ_pkg::DATA_W-1:0] cfg_rdata,
    input wire logic                       cfg_rvalid,
    // channel and supply outputs
    input wire logic [3:0]                 chan_drive,
    input wire logic [3:0]                 chan_lvds,
    input wire logic [3:0]                 chan_cml,
    input wire logic [3:0]                 chan_pecl,
    input wire logic                       pair_a_supply_select,
    input wire logic                       pair_b_supply_select
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic a_wr = cfg_write && cfg_addr == CH01_CTRL_OFS;
    wire logic b_wr = cfg_write && cfg_addr == CH23_CTRL_OFS;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    read_answer_a: assert property (cfg_read |=> cfg_rvalid)
        else $error("read not answered");
    answer_cause_a: assert property (cfg_rvalid |-> $past(cfg_read))
        else $error("answer without read");
    rdata_hold_a: assert property (!cfg_read |=> $stable(cfg_rdata))
        else $error("read data moved");
    unmapped_zero_a: assert property (cfg_read && (cfg_addr < 4'h5 ||
        cfg_addr > 4'h8) |=> cfg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    // the bench leaves one idle cycle between a write and the next read
    ctrl_readback_a: assert property (b_wr ##1 !cfg_write ##1 cfg_read &&
        cfg_addr == CH23_CTRL_OFS |=>
        cfg_rdata == {7'h00, $past(cfg_wdata[8:0], 3)})
        else $error("control readback wrong");
    supply_a_a: assert property (a_wr |-> ##2
        pair_a_supply_select == $past(cfg_wdata[0], 2))
        else $error("pair a supply wrong");
    supply_b_a: assert property (b_wr |-> ##2
        pair_b_supply_select == $past(cfg_wdata[0], 2))
        else $error("pair b supply wrong");
    drive_third_a: assert property (b_wr |-> ##2
        chan_drive[3] == ($past(cfg_wdata[6:5], 2) != 2'h0))
        else $error("channel 3 drive wrong");
    drive_second_a: assert property (b_wr |-> ##2
        chan_drive[2] == ($past(cfg_wdata[2:1], 2) != 2'h0))
        else $error("channel 2 drive wrong");
    type_third_a: assert property (b_wr |-> ##2
        chan_pecl[3] == ($past(cfg_wdata[8:7], 2) == 2'h3) &&
        chan_cml[3] == ($past(cfg_wdata[8:7], 2) == 2'h2))
        else $error("channel 3 type wrong");
    type_second_a: assert property (b_wr |-> ##2
        chan_lvds[2] == !$past(cfg_wdata[4], 2))
        else $error("channel 2 type wrong");
    cover property (b_wr && cfg_wdata[6:5] == EN_HIGH);
    cover property (cfg_read && cfg_addr == 4'h9);
    cover property (a_wr && cfg_wdata[0]);
endmodule // occ_bank_props

bind occ_config_bank occ_bank_props u_props (.*);

// >>> tb/tb_top.sv
// self-checking bench for the channel 0-3 configuration bank
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import occ_pkg::*;
    logic        mclk, rst_b, cfg_write, cfg_read, cfg_rvalid, sup_a, sup_b;
    logic [3:0]  cfg_addr, lvl, drv, lvds, cml, pecl;
    logic [15:0] cfg_wdata, cfg_rdata;
    int          miscompares, samples_checked;

    occ_config_bank DUT (.mclk(mclk), .rst_b(rst_b), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_write(cfg_write), .cfg_read(cfg_read),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .chan_level(lvl),
        .chan_drive(drv), .chan_lvds(lvds), .chan_cml(cml), .chan_pecl(pecl),
        .pair_a_supply_select(sup_a), .pair_b_supply_select(sup_b));

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(logic [3:0] a, logic [15:0] d);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_write = 1'b1;
        @(posedge mclk) #1 cfg_write = 1'b0;
        @(posedge mclk) #1;
    endtask

    task automatic rd(logic [3:0] a, logic [15:0] e);
        cfg_addr = a;
        cfg_read = 1'b1;
        @(posedge mclk) #1 cfg_read = 1'b0;
        chk("rvalid", 16'h0001, {15'h0000, cfg_rvalid});
        chk("rdata", e, cfg_rdata);
        @(posedge mclk) #1;
    endtask

    // counts over two periods so odd ratios show the ceil high phase
    task automatic meas(int ch, int ratio);
        int   highs;
        int   rises;
        logic prev;
        highs = 0;
        rises = 0;
        repeat (2 * ratio + 4) @(posedge mclk);
        #1 prev = lvl[ch];
        repeat (2 * ratio) begin
            @(posedge mclk) #1;
            if (lvl[ch] === 1'b1 && prev === 1'b0) rises++;
            if (lvl[ch] === 1'b1) highs++;
            prev = lvl[ch];
        end
        chk("div highs", 16'(2 * ((ratio + 1) / 2)), 16'(highs));
        chk("div rises", (ratio > 1) ? 16'h0002 : 16'h0000, 16'(rises));
    endtask

    task automatic close_out();
        if (miscompares == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        #(5 * 20000);
        miscompares++;
        close_out();
    end

    initial begin
        logic [1:0] k;
        logic [2:0] t;
        int         ra[3];
        int         rb[3];
        ra = '{256, 5, 2};
        rb = '{3, 1, 2};
        {rst_b, cfg_write, cfg_read, cfg_addr, cfg_wdata} = '0;
        repeat (3) @(posedge mclk);
        #1 rst_b = 1'b1;
        chk("reset type", {lvds, drv, sup_a, sup_b}, 10'h3C0);
        for (int a = 5; a < 9; a++) rd(4'(a), 16'h0000);
        rd(4'h9, 16'h0000);
        // reserved bits are written as zero by the host
        wr(CH01_CTRL_OFS, 16'h01FF);
        wr(CH01_DIV_OFS, 16'h00FF);
        wr(CH23_CTRL_OFS, 16'h0155);
        wr(CH23_DIV_OFS, 16'h00A5);
        chk("supplies", {sup_a, sup_b}, 2'h3);
        rd(CH01_CTRL_OFS, 16'h01FF);
        rd(CH01_DIV_OFS, 16'h00FF);
        rd(CH23_CTRL_OFS, 16'h0155);
        rd(CH23_DIV_OFS, 16'h00A5);
        chk("pair a drive", 16'h000F, {12'h000, drv[1:0], lvl[1:0]});
        chk("pair a type", 16'h0003, {lvds[1:0], cml[1:0], pecl[1:0]});
        wr(CH23_DIV_OFS, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            k = c[1:0];
            wr(CH23_CTRL_OFS, {7'h00, k, k, k, k, 1'b0});
            repeat (3) @(posedge mclk);
            #1 t = (k < 2) ? 3'h4 : (k == 2) ? 3'h2 : 3'h1;
            chk("supply b", sup_b, 1'b0);
            chk("drive", drv[3:2], (k != 0) ? 2'h3 : 2'h0);
            chk("level", lvl[3:2], {2{k[0]}});
            chk("type", {lvds[3:2], cml[3:2], pecl[3:2]},
                {{2{t[2]}}, {2{t[1]}}, {2{t[0]}}});
        end
        wr(CH01_CTRL_OFS, 16'h0022);
        wr(CH23_CTRL_OFS, 16'h0023);
        chk("supplies", {sup_a, sup_b}, 2'h1);
        for (int i = 0; i < 3; i++) begin
            wr(CH01_DIV_OFS, 16'(ra[i] - 1));
            wr(CH23_DIV_OFS, 16'(rb[i] - 1));
            meas(i % 2, ra[i]);
            meas(2 + i % 2, rb[i]);
        end
        close_out();
    end
endmodule // tb_top
